// ---- hdl/pmcs_regs.sv ----
/*
 pmcs_regs: basic control and status register bank of the management block.
 assumes: request fields are synchronous to ref_clk, one access per cycle,
 read data registered from the flops and answered one cycle after the request;
 the phy core reports link, fault, jabber and autonegotiation events.
*/
//
// Summary of operation
// - decode 0..31, control 0, status 1
// - read-only fields ignore writes silently
// - self-clearing bits drop when function completes
// - bit 15 runs phy reset, self-clears
// - bit 14 master loopback enable
// - bits 6,13 manual speed, strap default
// - manual speed used only without autonegotiation
// - bit 12 enables autonegotiation, default one
// - bit 10 isolates mac interface
// - bit 9 restarts autonegotiation, self-clears
// - bit 8 duplex, manual mode only
// - bit 7 enables collision test
// - status 15,10,9 read zero
// - status 14..11 read one
// - status 8 reads one
// - status 6 reads one
// - status 5 shows autonegotiation complete
// - status 4 latches remote fault
// - status 2 latches link down
// - status 1 latches jabber
// - status 3 reads one
// - status 0 reads one
`timescale 1ns/1ps
`default_nettype none
module pmcs_regs #(
    parameter int RST_CYC = pmcs_pkg::PHY_RST_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                strap_speed_1000,
    input  wire pmcs_pkg::pmcs_req_s req,
    output logic [15:0]              rdata,
    output logic                     rvalid,
    input  wire pmcs_pkg::pmcs_phy_s phy,
    output pmcs_pkg::pmcs_cfg_s      cfg
);
    import pmcs_pkg::*;

    // refuse reset lengths that the 8-bit sequence counter cannot hold
    if (RST_CYC < 1 || RST_CYC > 255) begin : g_rst_cyc_chk
        $error("RST_CYC out of range");
    end

    typedef enum logic [1:0] {
        PMCS_IDLE = 2'b01,
        PMCS_RST  = 2'b10
    } pmcs_st_e;

    pmcs_st_e    st_r;
    logic [7:0]  rst_cnt_r;
    logic        strap_r;
    logic        strap_done_r;
    logic        loopback_r, an_en_r, pwrdn_r, isolate_r, an_rst_r, duplex_r, coltest_r;
    logic [1:0]  speed_r;
    logic        rfault_r, link_r, jabber_r;
    logic [15:0] ctrl_rd, stat_rd;
    logic        wr_ctrl, rd_stat, soft_rst;

    assign wr_ctrl  = req.wr && (req.addr == PMCS_ADDR_CTRL);
    assign rd_stat  = req.rd && (req.addr == PMCS_ADDR_STAT);
    assign soft_rst = wr_ctrl && req.wdata[CTL_RESET];

    // strap captured after reset release
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_done_r <= 1'b0;
            strap_r      <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_r      <= strap_speed_1000;
        end
    end

    // phy reset sequence
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r      <= PMCS_IDLE;
            rst_cnt_r <= 8'h00;
        end else begin
            unique case (st_r)
                PMCS_IDLE: begin
                    if (soft_rst) begin
                        st_r      <= PMCS_RST;
                        rst_cnt_r <= 8'(RST_CYC - 1);
                    end
                end
                PMCS_RST: begin
                    if (rst_cnt_r == 8'h00) begin
                        st_r <= PMCS_IDLE;
                    end else begin
                        rst_cnt_r <= rst_cnt_r - 8'h01;
                    end
                end
                default: begin
                    st_r <= PMCS_IDLE;
                end
            endcase
        end
    end

    // read-write control fields; phy reset returns them to defaults
    always_ff @(posedge ref_clk) begin
        if (srst || st_r == PMCS_RST) begin
            loopback_r <= RST_OTHER;
            an_en_r    <= RST_AN_EN;
            pwrdn_r    <= RST_OTHER;
            isolate_r  <= RST_OTHER;
            duplex_r   <= RST_DUPLEX;
            coltest_r  <= RST_OTHER;
            speed_r    <= (srst || !strap_r) ? SPD_100 : SPD_1000;
        end else if (!strap_done_r) begin
            speed_r    <= strap_speed_1000 ? SPD_1000 : SPD_100;
        end else if (wr_ctrl && !req.wdata[CTL_RESET]) begin
            loopback_r <= req.wdata[CTL_LOOPBACK];
            an_en_r    <= req.wdata[CTL_AN_EN];
            pwrdn_r    <= req.wdata[CTL_PWRDN];
            isolate_r  <= req.wdata[CTL_ISOLATE];
            duplex_r   <= req.wdata[CTL_DUPLEX];
            coltest_r  <= req.wdata[CTL_COLTEST];
            speed_r    <= {req.wdata[CTL_SPD_MSB], req.wdata[CTL_SPD_LSB]};
        end
    end

    // restart autonegotiation, self-clearing
    always_ff @(posedge ref_clk) begin
        if (srst || st_r == PMCS_RST) begin
            an_rst_r <= 1'b0;
        end else if (wr_ctrl && req.wdata[CTL_AN_RST] && !req.wdata[CTL_RESET]) begin
            an_rst_r <= 1'b1;
        end else if (phy.an_restart_done) begin
            an_rst_r <= 1'b0;
        end
    end

    // latched status bits; the event wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (srst || st_r == PMCS_RST) begin
            rfault_r <= 1'b0;
            jabber_r <= 1'b0;
            link_r   <= 1'b0;
        end else begin
            if (phy.remote_fault) begin
                rfault_r <= 1'b1;
            end else if (rd_stat) begin
                rfault_r <= 1'b0;
            end
            if (phy.jabber) begin
                jabber_r <= 1'b1;
            end else if (rd_stat) begin
                jabber_r <= 1'b0;
            end
            if (!phy.link_up) begin
                link_r <= 1'b0;
            end else if (rd_stat) begin
                link_r <= 1'b1;
            end
        end
    end

    always_comb begin
        ctrl_rd               = 16'h0000;
        ctrl_rd[CTL_RESET]    = (st_r == PMCS_RST);
        ctrl_rd[CTL_LOOPBACK] = loopback_r;
        ctrl_rd[CTL_SPD_LSB]  = speed_r[0];
        ctrl_rd[CTL_AN_EN]    = an_en_r;
        ctrl_rd[CTL_PWRDN]    = pwrdn_r;
        ctrl_rd[CTL_ISOLATE]  = isolate_r;
        ctrl_rd[CTL_AN_RST]   = an_rst_r;
        ctrl_rd[CTL_DUPLEX]   = duplex_r;
        ctrl_rd[CTL_COLTEST]  = coltest_r;
        ctrl_rd[CTL_SPD_MSB]  = speed_r[1];
    end

    always_comb begin
        stat_rd              = STS_FIXED_ONES;
        stat_rd[STS_AN_DONE] = phy.an_done && an_en_r;
        stat_rd[STS_RFAULT]  = rfault_r;
        stat_rd[STS_LINK]    = link_r;
        stat_rd[STS_JABBER]  = jabber_r;
    end

    // read data register; unmapped and reserved addresses read zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata  <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                unique case (req.addr)
                    PMCS_ADDR_CTRL: rdata <= ctrl_rd;
                    PMCS_ADDR_STAT: rdata <= stat_rd;
                    default:        rdata <= 16'h0000;
                endcase
            end
        end
    end

    // configuration driven to the phy core
    always_comb begin
        cfg.loopback    = loopback_r;
        cfg.an_enable   = an_en_r;
        cfg.an_restart  = an_rst_r;
        cfg.power_down  = pwrdn_r;
        cfg.isolate     = isolate_r;
        cfg.col_test    = coltest_r;
        cfg.phy_reset   = (st_r == PMCS_RST);
        cfg.speed       = an_en_r ? SPD_1000 : speed_r;
        cfg.full_duplex = an_en_r ? 1'b1 : duplex_r;
    end
endmodule
`default_nettype wire

// ---- hdl/pmcs_pkg.sv ----
/*
 pmcs_pkg: address map, field positions, reset values and carrier structs
 for the management control and status register bank.
 assumes: a 5-bit register address and 16-bit data from the management port.
*/
package pmcs_pkg;
    localparam int          PMCS_ADDR_W        = 5;
    localparam int          PMCS_DATA_W        = 16;
    localparam logic [4:0]  PMCS_ADDR_CTRL     = 5'h00;
    localparam logic [4:0]  PMCS_ADDR_STAT     = 5'h01;
    localparam logic [4:0]  PMCS_ADDR_RSV0_LO  = 5'h0b;
    localparam logic [4:0]  PMCS_ADDR_RSV0_HI  = 5'h0e;
    localparam logic [4:0]  PMCS_ADDR_EXT_STAT = 5'h0f;
    localparam logic [4:0]  PMCS_ADDR_RSV1_LO  = 5'h10;
    localparam logic [4:0]  PMCS_ADDR_RSV1_HI  = 5'h11;
    localparam logic [4:0]  PMCS_ADDR_LPBK     = 5'h13;
    // control fields
    localparam int CTL_RESET    = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPD_LSB  = 13;
    localparam int CTL_AN_EN    = 12;
    localparam int CTL_PWRDN    = 11;
    localparam int CTL_ISOLATE  = 10;
    localparam int CTL_AN_RST   = 9;
    localparam int CTL_DUPLEX   = 8;
    localparam int CTL_COLTEST  = 7;
    localparam int CTL_SPD_MSB  = 6;
    // status fields
    localparam int STS_AN_DONE  = 5;
    localparam int STS_RFAULT   = 4;
    localparam int STS_LINK     = 2;
    localparam int STS_JABBER   = 1;
    // fixed status bits: 14:11, 8, 6, 3, 0 read one; 15, 10, 9, 7 read zero
    localparam logic [15:0] STS_FIXED_ONES  = 16'h7949;
    // reset values
    localparam logic        RST_AN_EN   = 1'b1;
    localparam logic        RST_DUPLEX  = 1'b1;
    localparam logic        RST_OTHER   = 1'b0;
    localparam logic [1:0]  SPD_10      = 2'b00;
    localparam logic [1:0]  SPD_100     = 2'b01;
    localparam logic [1:0]  SPD_1000    = 2'b10;
    // phy reset sequence length
    localparam int          PHY_RST_NS     = 40;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          PHY_RST_CYC    = (PHY_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pmcs_req_s;

    typedef struct packed {
        logic       loopback;
        logic       an_enable;
        logic       an_restart;
        logic       power_down;
        logic       isolate;
        logic       col_test;
        logic       phy_reset;
        logic [1:0] speed;
        logic       full_duplex;
    } pmcs_cfg_s;

    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
        logic an_done;
        logic an_restart_done;
    } pmcs_phy_s;
endpackage

// ---- test/pmcs_regs_assertions.sv ----
/*
 pmcs_regs_assertions: port-level checker for the control/status register bank.
 assumes: bound into pmcs_regs, single ref_clk domain, srst synchronous active high.
*/
`timescale 1ns/1ps
`default_nettype none
module pmcs_regs_assertions import pmcs_pkg::*; #(
    parameter int RST_CYC = PHY_RST_CYC
) (
    input wire logic                ref_clk,
    input wire logic                srst,
    input wire logic                strap_speed_1000,
    input wire pmcs_pkg::pmcs_req_s req,
    input wire logic [15:0]         rdata,
    input wire logic                rvalid,
    input wire pmcs_pkg::pmcs_phy_s phy,
    input wire pmcs_pkg::pmcs_cfg_s cfg
);
    logic [7:0]  rst_cnt_r;
    logic [15:0] wd_r;
    logic        wr_ctl;
    assign wr_ctl = req.wr && req.addr == PMCS_ADDR_CTRL && !req.wdata[CTL_RESET] && !cfg.phy_reset;
    // length of the current phy reset run
    always_ff @(posedge ref_clk) begin
        if (srst || !cfg.phy_reset) begin
            rst_cnt_r <= 8'h00;
        end else begin
            rst_cnt_r <= rst_cnt_r + 8'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        wd_r <= req.wdata;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_rd_answer; req.rd |=> rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_stat_fixed;
        rvalid && $past(req.addr) == PMCS_ADDR_STAT |-> (rdata & 16'hffc9) == STS_FIXED_ONES;
    endproperty
    a_stat_fixed: assert property (p_stat_fixed) else $error("fixed status bits");
    property p_rsv_zero; rvalid && $past(req.addr) > PMCS_ADDR_STAT |-> rdata == 16'h0000; endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("unmapped read nonzero");
    property p_rst_start;
        req.wr && req.addr == PMCS_ADDR_CTRL && req.wdata[CTL_RESET] && !cfg.phy_reset
            |=> cfg.phy_reset;
    endproperty
    a_rst_start: assert property (p_rst_start) else $error("phy reset not started");
    property p_rst_len; $fell(cfg.phy_reset) |-> rst_cnt_r == RST_CYC; endproperty
    a_rst_len: assert property (p_rst_len) else $error("phy reset length");
    property p_ctl_write;
        wr_ctl |=> {cfg.loopback, cfg.power_down, cfg.isolate, cfg.col_test, cfg.an_enable}
            == {wd_r[14], wd_r[11], wd_r[10], wd_r[7], wd_r[12]};
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write lost");
    property p_manual;
        wr_ctl && !req.wdata[CTL_AN_EN] && !(req.wdata[6] && req.wdata[13])
            |=> cfg.speed == {wd_r[6], wd_r[13]} && cfg.full_duplex == wd_r[8];
    endproperty
    a_manual: assert property (p_manual) else $error("manual speed or duplex");
    property p_an_force; wr_ctl && req.wdata[CTL_AN_EN] |=> cfg.speed == SPD_1000 && cfg.full_duplex; endproperty
    a_an_force: assert property (p_an_force) else $error("manual bits used in autoneg");
    property p_restart_clr; cfg.an_restart && phy.an_restart_done && !req.wr |=> !cfg.an_restart; endproperty
    a_restart_clr: assert property (p_restart_clr) else $error("restart not cleared");
    property p_ro_write;
        req.wr && req.addr != PMCS_ADDR_CTRL && !cfg.phy_reset && !phy.an_restart_done |=> $stable(cfg);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write elsewhere moved control");
    c_rst: cover property ($fell(cfg.phy_reset));
    c_stat: cover property (rvalid && $past(req.addr) == PMCS_ADDR_STAT);
    c_restart: cover property (cfg.an_restart && phy.an_restart_done);
endmodule
bind pmcs_regs pmcs_regs_assertions #(.RST_CYC(RST_CYC)) u_pmcs_chk (.ref_clk(ref_clk),
    .srst(srst), .strap_speed_1000(strap_speed_1000), .req(req), .rdata(rdata),
    .rvalid(rvalid), .phy(phy), .cfg(cfg));
`default_nettype wire

// ---- test/pmcs_regs_bench.sv ----
/*
 pmcs_regs_bench: self-checking bench driving the register bank ports directly.
 assumes: pmcs_pkg, pmcs_regs and the checker compiled first; phy reset shortened.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module pmcs_regs_bench;
    import pmcs_pkg::*;
    logic        ref_clk;
    logic        srst;
    logic        strap;
    pmcs_req_s   req;
    logic [15:0] rdata;
    logic        rvalid;
    pmcs_phy_s   phy;
    pmcs_cfg_s   cfg;
    int          err_total;
    int          checks;
    int          i;
    pmcs_regs #(.RST_CYC(4)) dut (.ref_clk(ref_clk), .srst(srst), .strap_speed_1000(strap),
        .req(req), .rdata(rdata), .rvalid(rvalid), .phy(phy), .cfg(cfg));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        tick();
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick();
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        tick();
        req.rd = 1'b1;
        req.addr = a;
        tick();
        req.rd = 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask
    // one-cycle inversion of a phy event bit
    task automatic pulse(input int b);
        tick();
        phy[b] = ~phy[b];
        tick();
        phy[b] = ~phy[b];
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        err_total = 0;
        checks = 0;
        srst = 1'b1;
        strap = 1'b1;
        req = '0;
        phy = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        rd(PMCS_ADDR_CTRL, 16'h1140);
        rd(PMCS_ADDR_STAT, 16'h7949);
        $display("test defaults done");
        wr(PMCS_ADDR_STAT, 16'h0000);
        wr(PMCS_ADDR_RSV0_LO, 16'hffff);
        wr(PMCS_ADDR_RSV1_HI, 16'hffff);
        rd(PMCS_ADDR_STAT, 16'h7949);
        rd(PMCS_ADDR_RSV0_LO, 16'h0000);
        rd(PMCS_ADDR_RSV1_HI, 16'h0000);
        $display("test read-only done");
        wr(PMCS_ADDR_CTRL, 16'h6c80);
        rd(PMCS_ADDR_CTRL, 16'h6c80);
        `CHK("cfg", 10'h272, cfg)
        for (i = 0; i < 3; i++) begin
            wr(PMCS_ADDR_CTRL, {2'b00, i[0], 6'h00, i[1], 6'h00});
            `CHK("speed", i[1:0], cfg.speed)
        end
        wr(PMCS_ADDR_CTRL, 16'h1000);
        `CHK("cfg", 10'h105, cfg)
        $display("test control done");
        wr(PMCS_ADDR_CTRL, 16'h1200);
        rd(PMCS_ADDR_CTRL, 16'h1200);
        pulse(0);
        rd(PMCS_ADDR_CTRL, 16'h1000);
        $display("test restart done");
        phy.an_done = 1'b1;
        rd(PMCS_ADDR_STAT, 16'h7969);
        phy.link_up = 1'b1;
        rd(PMCS_ADDR_STAT, 16'h7969);
        rd(PMCS_ADDR_STAT, 16'h796d);
        pulse(4);
        rd(PMCS_ADDR_STAT, 16'h7969);
        rd(PMCS_ADDR_STAT, 16'h796d);
        pulse(3);
        rd(PMCS_ADDR_STAT, 16'h797d);
        rd(PMCS_ADDR_STAT, 16'h796d);
        phy.jabber = 1'b1;
        rd(PMCS_ADDR_STAT, 16'h796f);
        rd(PMCS_ADDR_STAT, 16'h796f);
        phy.jabber = 1'b0;
        rd(PMCS_ADDR_STAT, 16'h796f);
        rd(PMCS_ADDR_STAT, 16'h796d);
        $display("test latches done");
        pulse(3);
        wr(PMCS_ADDR_CTRL, 16'h8a00);
        rd(PMCS_ADDR_CTRL, 16'h9140);
        for (i = 0; i < 50 && cfg.phy_reset === 1'b1; i++) begin
            tick();
        end
        if (cfg.phy_reset !== 1'b0) begin
            err_total++;
        end else begin
            rd(PMCS_ADDR_CTRL, 16'h1140);
            rd(PMCS_ADDR_STAT, 16'h7969);
            $display("test phy reset done");
            strap = 1'b0;
            srst = 1'b1;
            repeat (2) tick();
            srst = 1'b0;
            rd(PMCS_ADDR_CTRL, 16'h3100);
            $display("test strap low done");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
